/* verilog/npx_params.svh */
// timing counts, field positions and register offsets of the coprocessor port
`ifndef NPX_PARAMS_SVH
`define NPX_PARAMS_SVH

`define NPX_CLK_MHZ        100
`define NPX_DIV_RATIO      2'd3
`define NPX_CDIV_SETUP_CYC 16'd20
`define NPX_RST_MIN_CYC    16'd5
`define NPX_PWRUP_US       50
`define NPX_PWRUP_CYC      (`NPX_PWRUP_US * `NPX_CLK_MHZ)
`define NPX_EXEC_TICKS     4'd8
`define NPX_HCLK_HALF      2'd2
`define NPX_SETUP_CYC      3'd3
`define NPX_STROBE_CYC     3'd6
`define NPX_HOLD_CYC       3'd3
`define NPX_SYNC_IDLE      13'h0CFB
`define NPX_OPC_PROT       16'h00E4
`define NPX_OPC_CLEX       16'h00E2
`define NPX_ERRSUM_BIT     7
`define NPX_OFS_CTRL       8'h00
`define NPX_OFS_CMD        8'h04
`define NPX_OFS_STATUS     8'h08
`define NPX_OFS_RDATA      8'h0C
`define NPX_OFS_HSTAT      8'h10
`define NPX_CTRL_RST       5'h04
`define NPX_HSTAT_RST      5'h13

`endif

/* verilog/npx_pkg.sv */
// types of the coprocessor port: command codes for both ends, link states for the host end only
package npx_pkg;
   // command line pair {hi, lo}; 11 means no action
   typedef enum logic [1:0] {
      NPX_CMD_CTRL = 2'b00,
      NPX_CMD_DATA = 2'b01,
      NPX_CMD_OPC  = 2'b10,
      NPX_CMD_NONE = 2'b11
   } npx_cmd_type;

   typedef enum logic [1:0] {
      NPX_LK_IDLE   = 2'b00,
      NPX_LK_SETUP  = 2'b01,
      NPX_LK_STROBE = 2'b10,
      NPX_LK_HOLD   = 2'b11
   } npx_link_state_type;
endpackage : npx_pkg

/* verilog/npx_link_if.sv */
// pin-level link between host controller and coprocessor
`timescale 1ns/1ps
interface npx_link_if;
   logic        dev_reset;
   logic        clock_divide_select;
   logic        select_active_low_n;
   logic        select_active_high;
   logic        command_line_hi;
   logic        command_line_lo;
   logic        coproc_read_strobe_n;
   logic        coproc_write_strobe_n;
   logic        operand_transfer_request;
   logic        operand_transfer_ack_n;
   logic        busy;
   logic        error;
   logic        host_cpu_clock_in;
   logic        bus_status_1;
   logic        bus_status_0;
   logic        code_or_intack_status;
   logic        hold_acknowledge_in;
   logic        ready_n;
   logic [15:0] host_data_out;
   logic        host_data_oe;
   logic [15:0] dev_data_out;
   logic        dev_data_oe;
   logic [15:0] data_bus_lines;

   // resolved bus; an undriven bus reads as zero
   assign data_bus_lines = host_data_oe ? host_data_out :
                           dev_data_oe  ? dev_data_out  : 16'h0000;

   modport host (
      output dev_reset, clock_divide_select, select_active_low_n,
      output select_active_high, command_line_hi, command_line_lo,
      output coproc_read_strobe_n, coproc_write_strobe_n,
      output operand_transfer_ack_n, host_cpu_clock_in,
      output bus_status_1, bus_status_0, code_or_intack_status,
      output hold_acknowledge_in, ready_n, host_data_out, host_data_oe,
      input  operand_transfer_request, busy, error, data_bus_lines
   );
   modport dev (
      input  dev_reset, clock_divide_select, select_active_low_n,
      input  select_active_high, command_line_hi, command_line_lo,
      input  coproc_read_strobe_n, coproc_write_strobe_n,
      input  operand_transfer_ack_n, host_cpu_clock_in,
      input  bus_status_1, bus_status_0, code_or_intack_status,
      input  hold_acknowledge_in, ready_n, data_bus_lines,
      output operand_transfer_request, busy, error,
      output dev_data_out, dev_data_oe
   );
endinterface : npx_link_if

/* verilog/npx_host.sv */
// host-end controller driving the coprocessor link, run over ahb-lite
`timescale 1ns/1ps
`include "npx_params.svh"
module npx_host #(
   parameter int PWRUP_CYC = `NPX_PWRUP_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [31:0] haddr,
   input  wire logic        hsel,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   npx_link_if.host         link
);
   import npx_pkg::*;

   logic [7:0]         addr_r;
   logic               wr_r;
   logic [4:0]         ctrl_r;
   logic [4:0]         hstat_r;
   logic [15:0]        rdata_r;
   logic [15:0]        wdata_r;
   logic [1:0]         cmd_r;
   logic               rd_r;
   logic               cdiv_r;
   logic [15:0]        rst_cnt_r;
   logic [1:0]         hclk_cnt_r;
   logic               hclk_r;
   logic               ack_r;
   logic [2:0]         ph_r;
   npx_link_state_type st_r;

   ////////////////////////////////////////////////////////////////////////
   // ahb-lite slave: zero wait, always okay
   wire addr_ok  = hsel & htrans[1] & hready;
   wire wr_ctrl  = wr_r & (addr_r == `NPX_OFS_CTRL);
   wire wr_cmd   = wr_r & (addr_r == `NPX_OFS_CMD);
   wire wr_hstat = wr_r & (addr_r == `NPX_OFS_HSTAT);
   wire dev_rst  = rst_cnt_r != 16'h0000;
   wire lk_idle  = st_r == NPX_LK_IDLE;
   wire launch   = wr_cmd & lk_idle & ~dev_rst; // busy link ignores cmd
   wire ph_last  = (st_r == NPX_LK_SETUP  && ph_r == `NPX_SETUP_CYC) ||
                   (st_r == NPX_LK_STROBE && ph_r == `NPX_STROBE_CYC) ||
                   (st_r == NPX_LK_HOLD   && ph_r == `NPX_HOLD_CYC);
   wire [31:0] status_w = {26'h000_0000, cdiv_r, dev_rst, ~lk_idle,
      link.operand_transfer_request, link.error, link.busy};
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata =
      (addr_r == `NPX_OFS_CTRL)   ? {27'h000_0000, ctrl_r}  :
      (addr_r == `NPX_OFS_CMD)    ? {13'h0000, rd_r, cmd_r, wdata_r} :
      (addr_r == `NPX_OFS_STATUS) ? status_w :
      (addr_r == `NPX_OFS_RDATA)  ? {16'h0000, rdata_r} :
      (addr_r == `NPX_OFS_HSTAT)  ? {27'h000_0000, hstat_r} : 32'h0000_0000;

   // address phase capture
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         addr_r <= 8'h00;
         wr_r   <= 1'b0;
      end else begin
         addr_r <= {haddr[7:2], 2'b00};
         wr_r   <= addr_ok & hwrite;
      end
   end

   // software registers; soft reset bit self-clears
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ctrl_r  <= `NPX_CTRL_RST;
         hstat_r <= `NPX_HSTAT_RST;
      end else begin
         if (wr_ctrl)
            ctrl_r <= {hwdata[4:2], 1'b0, hwdata[0]};
         if (wr_hstat)
            hstat_r <= hwdata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // device reset: long after power-up, short on soft request
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rst_cnt_r <= 16'(PWRUP_CYC);
         cdiv_r    <= 1'b1;
      end else if (wr_ctrl && hwdata[1]) begin
         rst_cnt_r <= `NPX_CDIV_SETUP_CYC;
         cdiv_r    <= hwdata[0];   // mode only moves inside a reset
      end else if (dev_rst) begin
         rst_cnt_r <= rst_cnt_r - 16'h0001;
      end
   end

   // host cpu clock, a plain divided square wave
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         hclk_cnt_r <= 2'd0;
         hclk_r     <= 1'b0;
      end else if (hclk_cnt_r == `NPX_HCLK_HALF - 2'd1) begin
         hclk_cnt_r <= 2'd0;
         hclk_r     <= ~hclk_r;
      end else begin
         hclk_cnt_r <= hclk_cnt_r + 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link cycle: setup, strobe, hold with selects and data kept
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r    <= NPX_LK_IDLE;
         ph_r    <= 3'd1;
         cmd_r   <= NPX_CMD_NONE;
         rd_r    <= 1'b0;
         wdata_r <= 16'h0000;
         rdata_r <= 16'h0000;
         ack_r   <= 1'b0;
      end else begin
         ack_r <= ctrl_r[2] & link.operand_transfer_request & ~lk_idle;
         if (launch) begin
            st_r    <= NPX_LK_SETUP;
            ph_r    <= 3'd1;
            cmd_r   <= hwdata[17:16];
            rd_r    <= hwdata[18];
            wdata_r <= hwdata[15:0];
         end else if (ph_last) begin
            ph_r <= 3'd1;
            case (st_r)
               NPX_LK_SETUP: begin
                  st_r <= NPX_LK_STROBE;
               end
               NPX_LK_STROBE: begin
                  st_r <= NPX_LK_HOLD;
                  if (rd_r)
                     rdata_r <= link.data_bus_lines;
               end
               default: begin
                  st_r <= NPX_LK_IDLE;
               end
            endcase
         end else if (!lk_idle) begin
            ph_r <= ph_r + 3'd1;
         end
      end
   end

   // pins: both selects together mark an escape cycle
   assign link.dev_reset              = dev_rst;
   assign link.clock_divide_select    = cdiv_r;
   assign link.select_active_low_n    = lk_idle;
   assign link.select_active_high     = ~lk_idle;
   assign link.command_line_hi        = lk_idle | cmd_r[1];
   assign link.command_line_lo        = lk_idle | cmd_r[0];
   assign link.coproc_read_strobe_n   = ~(st_r == NPX_LK_STROBE & rd_r);
   assign link.coproc_write_strobe_n  = ~(st_r == NPX_LK_STROBE & ~rd_r);
   assign link.operand_transfer_ack_n = ~ack_r;
   assign link.host_data_out          = wdata_r;
   assign link.host_data_oe           = ~lk_idle & ~rd_r;
   assign link.host_cpu_clock_in      = hclk_r;
   assign link.bus_status_0           = hstat_r[0];
   assign link.bus_status_1           = hstat_r[1];
   assign link.code_or_intack_status  = hstat_r[2];
   assign link.hold_acknowledge_in    = hstat_r[3];
   assign link.ready_n                = hstat_r[4];
endmodule : npx_host

/* verilog/npx_dev.sv */
// coprocessor end of the host port: clock mode, strobes, request, status
// What this block does
// - clock mode high direct, low divide three
// - clock mode stable 20 cycles before release
// - reset abandons all work, goes dormant
// - reset held high over 4 cycles
// - reset release 50 us after power good
// - 16-bit data bus, no phase assumption
// - busy high while a command executes
// - error pin follows error summary bit
// - request high when ready to transfer
// - last request drops on ack or transfer
// - ack and strobes synchronised before use
// - selected read drives data to host
// - selected write takes data from host
// - selected only with low-sel low, high-sel high
// - no transfer unless selected; selects async
// - both command lines high means nothing
// - host status sampled on host clock edges
// - status inputs track host escape execution
// - hold-acknowledge means host owns bus
// - ready input marks host bus cycle end
// - real mode after reset, protected on command
`timescale 1ns/1ps
`include "npx_params.svh"
module npx_dev (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   npx_link_if.dev          link,
   input  wire logic [15:0] operand_in,
   input  wire logic        xfer_start,
   input  wire logic [3:0]  xfer_words,
   input  wire logic [5:0]  exception_set,
   output logic      [15:0] operand_out,
   output logic             operand_valid,
   output logic      [15:0] opcode_out,
   output logic             opcode_valid,
   output logic             protected_mode,
   output logic             timing_tick,
   output logic      [1:0]  host_bus_status,
   output logic             host_code_fetch,
   output logic             host_owns_bus,
   output logic             host_cycle_end,
   output logic      [7:0]  host_cycle_count
);
   import npx_pkg::*;

   localparam logic [12:0] SYNC_IDLE = `NPX_SYNC_IDLE;

   logic [12:0] raw_w;
   logic [12:0] meta_r;
   logic [12:0] sync_r;
   logic [12:0] prev_r;
   logic        rst;
   logic        cdiv_r;
   logic [1:0]  div_r;
   logic [3:0]  exec_r;
   logic        busy_r;
   logic [5:0]  exc_r;
   logic [5:0]  mask_r;
   logic        err_r;
   logic        pm_r;
   logic [3:0]  remain_r;
   logic        req_r;
   logic        wr_act_r;
   logic        rd_act_r;
   logic [1:0]  wcmd_r;
   logic [1:0]  rcmd_r;
   logic [15:0] wdat_r;
   logic [15:0] rdat_r;
   logic        hcyc_r;

   ////////////////////////////////////////////////////////////////////////
   // every link control but dev_reset and clock_divide_select is async to us: two flops each
   assign raw_w = {link.host_cpu_clock_in, link.bus_status_1,
                   link.bus_status_0, link.code_or_intack_status,
                   link.hold_acknowledge_in, link.ready_n,
                   link.operand_transfer_ack_n, link.coproc_read_strobe_n,
                   link.coproc_write_strobe_n, link.select_active_low_n,
                   link.select_active_high, link.command_line_hi,
                   link.command_line_lo};
   assign rst = reset | link.dev_reset;

   genvar gi;
   generate
      for (gi = 0; gi < 13; gi = gi + 1) begin : g_sync
         // meta stage feeds only the second stage
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               meta_r[gi] <= SYNC_IDLE[gi];
               sync_r[gi] <= SYNC_IDLE[gi];
               prev_r[gi] <= SYNC_IDLE[gi];
            end else begin
               meta_r[gi] <= raw_w[gi];
               sync_r[gi] <= meta_r[gi];
               prev_r[gi] <= sync_r[gi];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // select and command decode on synchronised copies
   wire       selected = ~sync_r[3] & sync_r[2];
   wire [1:0] cmd_w    = sync_r[1:0];
   wire       no_act   = cmd_w == NPX_CMD_NONE;
   wire       rd_act   = selected & ~no_act & ~sync_r[5];
   wire       wr_act   = selected & ~no_act & ~sync_r[4];
   wire       wr_end   = wr_act_r & ~wr_act;
   wire       rd_end   = rd_act_r & ~rd_act;
   // only a fresh ack counts: a stale one from the last word lingers
   wire       ack_seen = ~sync_r[6] & prev_r[6];
   wire       xfer_hit = (wr_end & wcmd_r == NPX_CMD_DATA) |
                         (rd_end & rcmd_r == NPX_CMD_DATA);
   wire       opc_hit  = wr_end & wcmd_r == NPX_CMD_OPC;
   wire       do_prot  = opc_hit & wdat_r == `NPX_OPC_PROT;
   wire       do_clex  = opc_hit & wdat_r == `NPX_OPC_CLEX;
   wire       do_exec  = opc_hit & ~do_prot & ~do_clex;
   wire       errsum_w = |(exc_r & ~mask_r);
   wire [15:0] status_w = {busy_r, 7'h00, errsum_w, pm_r, exc_r};
   wire       tick     = cdiv_r | div_r == `NPX_DIV_RATIO - 2'd1;
   wire       hedge    = sync_r[12] & ~prev_r[12];

   ////////////////////////////////////////////////////////////////////////
   // timing base: mode caught while reset holds, then frozen
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cdiv_r <= link.clock_divide_select;   // clocked, not a reset value
         div_r <= 2'd0;
      end else if (div_r == `NPX_DIV_RATIO - 2'd1) begin
         div_r <= 2'd0;
      end else begin
         div_r <= div_r + 2'd1;
      end
   end

   // strobe window: data sampled only while the strobe is seen active
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
         wcmd_r   <= NPX_CMD_NONE;
         rcmd_r   <= NPX_CMD_NONE;
         wdat_r   <= 16'h0000;
      end else begin
         wr_act_r <= wr_act;
         rd_act_r <= rd_act;
         if (wr_act) begin
            wcmd_r <= cmd_w;
            wdat_r <= link.data_bus_lines;
         end
         if (rd_act)
            rcmd_r <= cmd_w;
      end
   end

   // read data staged every cycle for the selected command
   always_ff @(posedge clk_sys) begin
      if (rst)
         rdat_r <= 16'h0000;
      else if (cmd_w == NPX_CMD_DATA)
         rdat_r <= operand_in;
      else if (cmd_w == NPX_CMD_OPC)
         rdat_r <= {10'h000, mask_r};
      else
         rdat_r <= status_w;
   end
   assign link.dev_data_out = rdat_r;
   assign link.dev_data_oe  = rd_act;

   ////////////////////////////////////////////////////////////////////////
   // command execution, error summary, mode
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         exec_r       <= 4'h0;
         busy_r       <= 1'b0;
         exc_r        <= 6'h00;
         mask_r       <= 6'h3F;
         err_r        <= 1'b0;
         pm_r         <= 1'b0;
         opcode_out   <= 16'h0000;
         opcode_valid <= 1'b0;
      end else begin
         opcode_valid <= do_exec;
         if (do_exec) begin
            exec_r     <= `NPX_EXEC_TICKS;
            busy_r     <= 1'b1;
            opcode_out <= wdat_r;
         end else if (tick && exec_r != 4'h0) begin
            exec_r <= exec_r - 4'h1;
            busy_r <= exec_r != 4'h1;
         end
         if (wr_end && wcmd_r == NPX_CMD_CTRL)
            mask_r <= wdat_r[5:0];
         // a new exception beats a clear in the same cycle
         exc_r <= (exc_r & ~{6{do_clex}}) | exception_set;
         err_r <= errsum_w;
         if (do_prot)
            pm_r <= 1'b1;   // sticky until reset
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // operand channel request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         remain_r      <= 4'h0;
         req_r         <= 1'b0;
         operand_out   <= 16'h0000;
         operand_valid <= 1'b0;
      end else begin
         operand_valid <= wr_end & wcmd_r == NPX_CMD_DATA;
         if (wr_end && wcmd_r == NPX_CMD_DATA)
            operand_out <= wdat_r;
         if (xfer_start && remain_r == 4'h0) begin
            remain_r <= xfer_words;
            req_r    <= xfer_words != 4'h0;
         end else if (xfer_hit && remain_r != 4'h0) begin
            remain_r <= remain_r - 4'h1;
            req_r    <= remain_r != 4'h1;
         end else if (ack_seen && remain_r == 4'h1) begin
            req_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host status, sampled on host clock rising edges
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         host_bus_status  <= 2'b11;
         host_code_fetch  <= 1'b0;
         host_owns_bus    <= 1'b0;
         host_cycle_end   <= 1'b0;
         host_cycle_count <= 8'h00;
         hcyc_r           <= 1'b0;
      end else begin
         host_cycle_end <= 1'b0;
         if (hedge) begin
            host_bus_status <= sync_r[11:10];
            host_code_fetch <= sync_r[9];
            host_owns_bus   <= sync_r[8];
            if (sync_r[11:10] != 2'b11)
               hcyc_r <= 1'b1;
            else if (hcyc_r && !sync_r[7]) begin
               hcyc_r           <= 1'b0;
               host_cycle_end   <= 1'b1;
               host_cycle_count <= host_cycle_count + 8'h01;
            end
         end
      end
   end

   assign link.busy                     = busy_r;
   assign link.error                    = err_r;
   assign link.operand_transfer_request = req_r;
   assign protected_mode                = pm_r;
   assign timing_tick                   = tick;
endmodule : npx_dev

/* verif/npx_chk.sv */
// concurrent checks on the pins between host and coprocessor ends
`timescale 1ns/1ps
module npx_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic dev_reset,
   input wire logic clock_divide_select,
   input wire logic select_active_low_n,
   input wire logic select_active_high,
   input wire logic command_line_hi,
   input wire logic command_line_lo,
   input wire logic coproc_read_strobe_n,
   input wire logic coproc_write_strobe_n,
   input wire logic operand_transfer_request,
   input wire logic busy,
   input wire logic error,
   input wire logic host_data_oe,
   input wire logic dev_data_oe
);
   logic [4:0] cdiv_age_r;
   logic       cdiv_last_r;
   wire        sel_on = !select_active_low_n && select_active_high;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   ////////////////////////////////////////
   // age of the clock mode level; saturates so a long hold never wraps
   always_ff @(posedge clk_sys) begin
      cdiv_last_r <= clock_divide_select;
      if (reset || clock_divide_select != cdiv_last_r)
         cdiv_age_r <= 5'h00;
      else if (cdiv_age_r != 5'h1f)
         cdiv_age_r <= cdiv_age_r + 5'h01;
   end
   // two cycles of slack: the mode may be latched just after reset rises
   a_mode_settled: assert property ($fell(dev_reset) |->
      cdiv_age_r >= 5'h12)
      else $error("clock mode changed too near reset release");
   a_reset_long: assert property ($rose(dev_reset) |-> dev_reset[*5])
      else $error("device reset pulse too short");
   a_reset_quiet: assert property (dev_reset[*3] |-> !busy && !error
      && !operand_transfer_request && !dev_data_oe)
      else $error("device active while held in reset");
   a_bus_no_clash: assert property (!(host_data_oe && dev_data_oe))
      else $error("both ends drive the data bus");
   a_oe_selected: assert property (dev_data_oe |-> sel_on
      && !(command_line_hi && command_line_lo))
      else $error("device drives bus while unselected");
   a_strobe_sel: assert property (!(coproc_read_strobe_n
      && coproc_write_strobe_n) |-> sel_on)
      else $error("strobe without both selects");
   a_wr_width: assert property ($fell(coproc_write_strobe_n) |->
      !coproc_write_strobe_n[*6] ##1 coproc_write_strobe_n)
      else $error("write strobe width wrong");
   a_idle_cmd: assert property (select_active_low_n |->
      command_line_hi && command_line_lo)
      else $error("command lines not idle while unselected");
endmodule : npx_chk

/* verif/tb_top.sv */
// self-checking bench joining the host controller and coprocessor ends
`timescale 1ns/1ps
module tb_top;
   import npx_pkg::*;
   logic        clk_sys, reset, hwrite, xfer_start, hreadyout;
   logic        operand_valid, opcode_valid, protected_mode, timing_tick;
   logic        host_code_fetch, host_owns_bus, host_cycle_end;
   logic [1:0]  htrans, host_bus_status;
   logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
   logic [15:0] operand_in, operand_out, opcode_out, op;
   logic [3:0]  xfer_words;
   logic [5:0]  exception_set;
   logic [7:0]  host_cycle_count, n0;
   logic [16:0] exq[$];
   int          fails, checked, ticks, busy_cyc, ends;
   npx_link_if lk ();
   npx_host #(.PWRUP_CYC(40)) u_npx_host (.clk_sys, .reset, .haddr,
      .hsel(1'b1), .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .link(lk));
   npx_dev u_npx_dev (.clk_sys, .reset, .link(lk), .operand_in,
      .xfer_start, .xfer_words, .exception_set, .operand_out,
      .operand_valid, .opcode_out, .opcode_valid, .protected_mode,
      .timing_tick, .host_bus_status, .host_code_fetch, .host_owns_bus,
      .host_cycle_end, .host_cycle_count);
   npx_chk u_npx_chk (.clk_sys, .reset, .dev_reset(lk.dev_reset),
      .clock_divide_select(lk.clock_divide_select),
      .select_active_low_n(lk.select_active_low_n),
      .select_active_high(lk.select_active_high),
      .command_line_hi(lk.command_line_hi),
      .command_line_lo(lk.command_line_lo),
      .coproc_read_strobe_n(lk.coproc_read_strobe_n),
      .coproc_write_strobe_n(lk.coproc_write_strobe_n),
      .operand_transfer_request(lk.operand_transfer_request),
      .busy(lk.busy), .error(lk.error),
      .host_data_oe(lk.host_data_oe), .dev_data_oe(lk.dev_data_oe));
   ////////////////////////////////////////
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // one single ahb-lite transfer; waits on hready, never on a count
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      haddr  <= {24'h0000_00, a};
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   // poll status until no link cycle, device reset or command runs
   task automatic link_idle;
      for (int n = 0; n < 300; n++) begin
         ahb(1'b0, 8'h08, 32'h0000_0000);
         if ({rd[4:3], rd[0]} === 3'b000) break;
      end
      cmp({rd[4:3], rd[0]}, 3'b000);
   endtask : link_idle
   task automatic send(input npx_cmd_type c, input logic r,
                       input logic [15:0] d);
      ahb(1'b1, 8'h04, {13'h0000, r, c, d});
      link_idle();
   endtask : send
   task automatic stop_test;
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   // model of the words the device should hand on, in order
   always @(posedge clk_sys) begin
      if (operand_valid === 1'b1 || opcode_valid === 1'b1)
         cmp({15'h0, opcode_valid, opcode_valid ? opcode_out : operand_out},
             {15'h0, exq.size() ? exq.pop_front() : 17'h1_ffff});
      ticks = ticks + (timing_tick === 1'b1);
      busy_cyc = busy_cyc + (lk.busy === 1'b1);
      ends = ends + (host_cycle_end === 1'b1);
   end
   initial begin
      #300us;
      fails++;
      stop_test();
   end
   ////////////////////////////////////////
   initial begin
      reset = 1'b1;
      {htrans, haddr, hwrite, hwdata, xfer_start} = '0;
      {operand_in, xfer_words, exception_set} = '0;
      lfsr = 32'h0000_9bf8;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      ahb(1'b0, 8'h08, 32'h0);
      cmp(rd[4], 1'b1);
      link_idle();
      ahb(1'b0, 8'h00, 32'h0); cmp(rd, 32'h0000_0004);
      ahb(1'b0, 8'h10, 32'h0); cmp(rd, 32'h0000_0013);
      ahb(1'b0, 8'h20, 32'h0); cmp(rd, 32'h0000_0000);
      @(negedge clk_sys) ticks = 0;
      repeat (30) @(negedge clk_sys);
      cmp(ticks, 30);
      // random operands out and back, then an ignored command
      for (int i = 0; i < 4; i++) begin
         lfsr = nxt(lfsr);
         exq.push_back({1'b0, lfsr[15:0]});
         send(NPX_CMD_DATA, 1'b0, lfsr[15:0]);
         operand_in <= lfsr[31:16];
         send(NPX_CMD_DATA, 1'b1, 16'h0000);
         ahb(1'b0, 8'h0C, 32'h0); cmp(rd, {16'h0, lfsr[31:16]});
      end
      send(NPX_CMD_NONE, 1'b0, 16'hffff);
      op = {8'h01, lfsr[7:0]};
      exq.push_back({1'b1, op});
      @(negedge clk_sys) busy_cyc = 0;
      send(NPX_CMD_OPC, 1'b0, op);
      cmp(busy_cyc inside {[8:9]}, 1);
      // masked exception stays quiet, unmasked one shows, clear drops it
      exception_set <= 6'h04;
      repeat (2) @(posedge clk_sys);
      exception_set <= 6'h00;
      repeat (8) @(posedge clk_sys);
      cmp(lk.error, 0);
      send(NPX_CMD_CTRL, 1'b0, 16'h0000);
      repeat (8) @(posedge clk_sys);
      cmp(lk.error, 1);
      send(NPX_CMD_OPC, 1'b0, 16'h00e4);
      cmp(protected_mode, 1);
      send(NPX_CMD_OPC, 1'b0, 16'h00e2);
      repeat (8) @(posedge clk_sys);
      cmp(lk.error, 0);
      // two-word request: survives the first word, gone after the second
      xfer_words <= 4'h2;
      xfer_start <= 1'b1;
      @(posedge clk_sys) xfer_start <= 1'b0;
      repeat (3) @(posedge clk_sys);
      cmp(lk.operand_transfer_request, 1);
      for (int i = 0; i < 2; i++) begin
         exq.push_back({1'b0, 16'h5a5a});
         send(NPX_CMD_DATA, 1'b0, 16'h5a5a);
         cmp(lk.operand_transfer_request, !i);
      end
      // host status: bus owned, a cycle runs, then ends on ready
      ahb(1'b1, 8'h10, 32'h0000_001e);
      repeat (20) @(posedge clk_sys);
      cmp({host_code_fetch, host_owns_bus, host_bus_status}, 4'b1110);
      n0 = host_cycle_count;
      ahb(1'b1, 8'h10, 32'h0000_000b);
      repeat (20) @(posedge clk_sys);
      cmp(host_cycle_count, n0 + 8'h01);
      cmp(ends, 1);
      // soft reset into divide-by-three leaves protected mode
      ahb(1'b1, 8'h00, 32'h0000_0006);
      link_idle();
      cmp(protected_mode, 0);
      @(negedge clk_sys) ticks = 0;
      repeat (30) @(negedge clk_sys);
      cmp(ticks, 10);
      cmp(exq.size(), 0);
      stop_test();
   end
endmodule : tb_top
